// [hdl/mcb_bus.sv]
// Implementation choices: the address map and register access over APB.
module mcb_bus (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Control bus slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Store requests from the core, queued in the write buffer.
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [31:0] wr_addr,
  input wire logic [1:0] wr_size,
  input wire logic [31:0] wr_data,
  // Read requests from the core.
  input wire logic rd_req_valid,
  output logic rd_req_ready,
  input wire logic [31:0] rd_addr,
  input wire logic [1:0] rd_size,
  input wire logic rd_quad,
  input wire logic rd_miss,
  input wire logic rd_instr,
  // Read buffer output toward the core.
  output logic rdata_valid,
  output logic [31:0] rdata,
  output logic rdata_last,
  // Strap values caught during reset.
  output logic boot_rom_halfword_opt,
  output logic boot_rom_byte_opt,
  output logic spare_high_opt,
  output logic long_latch_hold_opt,
  // External memory pins.
  input wire logic [1:0] port_width,
  input wire logic mem_ack,
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe,
  output logic ale,
  output logic diag,
  input wire logic [3:0] low_addr_in,
  output logic [3:0] low_addr_out,
  output logic low_addr_oe
);
  import mcb_pkg::*;

  // Lane enable mask of a datum on a full-width port.
  function automatic logic [3:0] lane_mask(logic [1:0] size, logic [1:0] off, logic big);
    logic [3:0] base;
    logic [3:0] little;
    base = (size == MCB_SZ_BYTE) ? 4'h1 : ((size == MCB_SZ_HALF) ? 4'h3 : 4'hF);
    little = base << off;
    return big ? {little[0], little[1], little[2], little[3]} : little;
  endfunction : lane_mask

  // Byte position within the word of the datum currently on a narrow port.
  function automatic logic [1:0] lane_shift(logic [1:0] port, logic [1:0] a, logic big);
    logic [1:0] s;
    s = 2'h0;
    if (port == MCB_SZ_BYTE) begin
      s = big ? 2'h3 - a : a;
    end else if (port == MCB_SZ_HALF) begin
      s = big ? {~a[1], 1'b0} : {a[1], 1'b0};
    end
    return s;
  endfunction : lane_shift

  mcb_state_t state;  // Sequencer state.
  mcb_state_t next_state;
  logic [1:0] ctrl;  // Strobe hold and byte order bits.
  logic [3:0] strap;  // Configuration caught on the low address pins.
  logic [31:0] cur_addr;  // Address of the transfer in flight.
  logic [1:0] cur_size;
  logic [1:0] cur_port;
  logic cur_write;
  logic cur_quad;
  logic cur_miss;
  logic cur_instr;
  logic [31:0] cur_data;  // Store data of the transfer in flight.
  logic [3:0] low_addr;  // Datum now expected.
  logic [4:0] beats_left;  // Data beats still owed.
  logic [31:0] acc;  // Read word being assembled from narrow beats.
  logic drive_low;  // Low address pins driven once reset is over.

  // Write buffer signals.
  logic wb_valid;
  logic wb_pop;
  logic [MCB_WBUF_WIDTH-1:0] wb_data;

  // Named decode and datapath wires.
  logic hold_strobes;
  logic big_endian;
  logic take_write;
  logic take_read;
  logic beat_done;
  logic last_beat;
  logic [3:0] step;
  logic [3:0] next_low;
  logic [1:0] shift;
  logic [4:0] start_beats;
  logic [3:0] strobes;
  logic [31:0] beat_in;
  logic [31:0] merged;
  logic word_done;
  logic apb_setup;
  logic apb_write;
  logic hit_ctrl;
  logic hit_status;

  mcb_fifo #(
    .WIDTH(MCB_WBUF_WIDTH),
    .DEPTH(MCB_WBUF_DEPTH)
  ) u_wbuf (
    .clock(clock),
    .resetn(resetn),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_addr, wr_size, wr_data}),
    .out_valid(wb_valid),
    .out_ready(wb_pop),
    .out_data(wb_data)
  );

  assign hold_strobes = ctrl[MCB_CTRL_HOLD_BIT];
  assign big_endian = ctrl[MCB_CTRL_BIG_BIT];

  // Buffered stores go first so a later read never overtakes an older store.
  assign take_write = (state == MCB_ST_IDLE) && wb_valid;
  assign take_read = (state == MCB_ST_IDLE) && !wb_valid && rd_req_valid;
  assign wb_pop = take_write;
  assign rd_req_ready = (state == MCB_ST_IDLE) && !wb_valid;

  // Beat count: wider datum than port means several beats; quads cover 16 bytes.
  assign start_beats = take_read && rd_quad ? 5'(5'h01 << (MCB_QUAD_LOG2 - {1'b0, port_width}))
                     : ((take_write ? wb_data[33:32] : rd_size) > port_width)
                     ? 5'(5'h01 << ((take_write ? wb_data[33:32] : rd_size) - port_width))
                     : 5'h01;

  assign beat_done = (state == MCB_ST_DATA) && mem_ack;
  assign last_beat = (beats_left == 5'h01);
  assign step = 4'(4'h1 << cur_port);
  assign next_low = low_addr + step;
  assign shift = lane_shift(cur_port, low_addr[1:0], big_endian);

  // Strobes are computed for every port width; narrow-port decoders ignore them.
  assign strobes = (hold_strobes && !cur_write) ? 4'hF
                 : ~lane_mask(cur_quad ? MCB_SZ_WORD : cur_size, cur_addr[1:0],
                   big_endian);

  // A narrow port returns its bytes on the low lanes; place them by byte order.
  assign beat_in = (cur_port == MCB_SZ_BYTE) ? {24'h000000, ad_in[7:0]}
                 : ((cur_port == MCB_SZ_HALF) ? {16'h0000, ad_in[15:0]} : ad_in);
  assign merged = (cur_port == MCB_SZ_WORD) ? ad_in : (acc | (beat_in << {shift, 3'b000}));
  assign word_done = (cur_port == MCB_SZ_WORD) || (next_low[1:0] == 2'h0) || last_beat;

  // Pin drive: address and strobes, then store data or release on reads.
  assign ale = (state == MCB_ST_ADDR);
  assign ad_oe = (state == MCB_ST_ADDR) || ((state == MCB_ST_DATA) && cur_write);
  assign ad_out = (state == MCB_ST_ADDR) ? {cur_addr[31:4], strobes}
                : ((state == MCB_ST_DATA) ? (cur_data >> {shift, 3'b000}) : 32'h00000000);
  // Miss flag in the address slot, fetch flag in the data slot; writes show low.
  assign diag = cur_write ? 1'b0
              : ((state == MCB_ST_ADDR) ? cur_miss
              : ((state == MCB_ST_DATA) && cur_instr));
  assign low_addr_out = low_addr;
  assign low_addr_oe = drive_low;

  assign boot_rom_halfword_opt = strap[0];
  assign boot_rom_byte_opt = strap[1];
  assign spare_high_opt = strap[2];
  assign long_latch_hold_opt = strap[3];

  // Sequencer next state: one address cycle, then data until the last beat.
  always_comb begin
    next_state = state;
    unique case (state)
      MCB_ST_IDLE: begin
        if (take_write || take_read) begin
          next_state = MCB_ST_ADDR;
        end
      end
      MCB_ST_ADDR: begin
        next_state = MCB_ST_DATA;
      end
      MCB_ST_DATA: begin
        if (mem_ack && last_beat) begin
          next_state = MCB_ST_IDLE;
        end
      end
      default: begin
        next_state = MCB_ST_IDLE;
      end
    endcase
  end

  // Sequencer state register.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= MCB_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Latch the transfer when it is accepted from either request source.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cur_addr <= 32'h00000000;
      cur_size <= MCB_SZ_BYTE;
      cur_port <= MCB_SZ_WORD;
      cur_write <= 1'b0;
      cur_quad <= 1'b0;
      cur_miss <= 1'b0;
      cur_instr <= 1'b0;
      cur_data <= 32'h00000000;
    end else if (take_write || take_read) begin
      cur_addr <= take_write ? wb_data[65:34] : rd_addr;
      cur_size <= take_write ? wb_data[33:32] : rd_size;
      cur_port <= port_width;
      cur_write <= take_write;
      cur_quad <= take_read && rd_quad;
      cur_miss <= take_read && rd_miss;
      cur_instr <= take_read && rd_instr;
      cur_data <= take_write ? wb_data[31:0] : 32'h00000000;
    end
  end

  // Low address and beat counter: target first, or zero for quads, then step.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      low_addr <= 4'h0;
      beats_left <= 5'h00;
    end else if (take_write || take_read) begin
      low_addr <= (take_read && rd_quad) ? 4'h0
                : (take_write ? wb_data[37:34] : rd_addr[3:0]);
      beats_left <= start_beats;
    end else if (beat_done) begin
      low_addr <= next_low;
      beats_left <= beats_left - 5'h01;
    end
  end

  // Read buffer: assemble narrow beats and hand each full word to the core.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      acc <= 32'h00000000;
      rdata <= 32'h00000000;
      rdata_valid <= 1'b0;
      rdata_last <= 1'b0;
    end else begin
      rdata_valid <= beat_done && !cur_write && word_done;
      rdata_last <= beat_done && !cur_write && last_beat;
      if (beat_done && !cur_write) begin
        acc <= word_done ? 32'h00000000 : merged;
        if (word_done) begin
          rdata <= merged;
        end
      end
    end
  end

  // Straps follow the pins while reset is held and freeze at its release.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      strap <= low_addr_in;
    end
  end

  // Low address pins stay released during reset so the straps can be read.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      drive_low <= 1'b0;
    end else begin
      drive_low <= 1'b1;
    end
  end

  // Control bus decode; the slave never inserts wait states.
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign hit_ctrl = (paddr == MCB_CTRL_OFF);
  assign hit_status = (paddr == MCB_STATUS_OFF);
  assign pready = 1'b1;
  // Unmapped addresses and writes to the read-only status word are errors.
  assign pslverr = psel && penable && !(hit_ctrl || (hit_status && !pwrite));

  // Control register write, taken only in the access phase.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl <= MCB_CTRL_RESET;
    end else if (apb_write && hit_ctrl) begin
      ctrl <= pwdata[1:0];
    end
  end

  // Read data are captured in the setup cycle and stand through the access.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      prdata <= hit_ctrl ? {30'h0, ctrl}
              : (hit_status ? {26'h0, !wr_ready, state != MCB_ST_IDLE, strap}
              : 32'h00000000);
    end
  end

  // Checks on the pin sequencing.
  sequence seq_read_addr;
    ale && !cur_write;
  endsequence

  sequence seq_read_data;
    (state == MCB_ST_DATA) && !cur_write;
  endsequence

  a_ale_addr_drive: assert property (@(posedge clock) disable iff (!resetn)
    ale |-> ad_oe && (ad_out[31:4] == cur_addr[31:4]))
    else $error("latch strobe without driven address");

  a_addr_then_data: assert property (@(posedge clock) disable iff (!resetn)
    ale |=> (state == MCB_ST_DATA) && !ale)
    else $error("address phase not followed by data phase");

  a_read_strobe_hold: assert property (@(posedge clock) disable iff (!resetn)
    seq_read_addr and hold_strobes |-> (ad_out[3:0] == 4'hF))
    else $error("strobes active on read while held");

  a_word_strobes: assert property (@(posedge clock) disable iff (!resetn)
    ale && cur_write && (cur_size == MCB_SZ_WORD) |-> (ad_out[3:0] == 4'h0))
    else $error("word store does not enable all lanes");

  a_read_release: assert property (@(posedge clock) disable iff (!resetn)
    seq_read_data |-> !ad_oe)
    else $error("shared lines driven during read data");

  a_write_data: assert property (@(posedge clock) disable iff (!resetn)
    ale && cur_write && (cur_port == MCB_SZ_WORD) |=> ad_oe && (ad_out == cur_data))
    else $error("store data not driven");

  a_diag_slots: assert property (@(posedge clock) disable iff (!resetn)
    seq_read_addr ##1 seq_read_data |-> (diag == cur_instr) && ($past(diag) == cur_miss))
    else $error("diagnostic slots wrong");

  a_quad_from_zero: assert property (@(posedge clock) disable iff (!resetn)
    seq_read_addr and cur_quad |-> (low_addr_out == 4'h0) ##1 (low_addr_out == 4'h0))
    else $error("quad read does not start at zero");

  a_low_step: assert property (@(posedge clock) disable iff (!resetn)
    beat_done && !last_beat |=> (low_addr_out == 4'($past(low_addr_out) + $past(step))))
    else $error("low address did not advance by port width");

  a_word_return: assert property (@(posedge clock) disable iff (!resetn)
    beat_done && !cur_write && (cur_port == MCB_SZ_WORD) |=> rdata_valid
      && (rdata == $past(ad_in)))
    else $error("read word not placed in read buffer");

endmodule : mcb_bus

// [hdl/mcb_pkg.sv]
package mcb_pkg;

  // Register byte offsets on the control bus.
  localparam logic [11:0] MCB_CTRL_OFF = 12'h000;
  localparam logic [11:0] MCB_STATUS_OFF = 12'h004;

  // Control register field positions and reset value.
  localparam int MCB_CTRL_HOLD_BIT = 0;
  localparam int MCB_CTRL_BIG_BIT = 1;
  localparam logic [1:0] MCB_CTRL_RESET = 2'h0;

  // Status register field positions.
  localparam int MCB_STATUS_STRAP_LSB = 0;
  localparam int MCB_STATUS_BUSY_BIT = 4;
  localparam int MCB_STATUS_FULL_BIT = 5;

  // Datum size and port width codes, both as log2 of the byte count.
  localparam logic [1:0] MCB_SZ_BYTE = 2'h0;
  localparam logic [1:0] MCB_SZ_HALF = 2'h1;
  localparam logic [1:0] MCB_SZ_WORD = 2'h2;

  // Quad read length expressed as log2 of its byte count.
  localparam logic [2:0] MCB_QUAD_LOG2 = 3'h4;

  // Write buffer depth and entry width parameters.
  localparam int MCB_WBUF_DEPTH = 4;
  localparam int MCB_WBUF_WIDTH = 66;

  // Bus sequencer states.
  typedef enum logic [1:0] {
    MCB_ST_IDLE = 2'b00,
    MCB_ST_ADDR = 2'b01,
    MCB_ST_DATA = 2'b10
  } mcb_state_t;

endpackage : mcb_pkg

// [hdl/mcb_fifo.sv]
module mcb_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import mcb_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
  logic [AW-1:0] wr_ptr;  // Next slot to fill.
  logic [AW-1:0] rd_ptr;  // Oldest slot.
  logic [AW:0] count;  // Number of words held.
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Head word comes straight from the storage array indexed by a register.
  assign out_data = mem[rd_ptr];

  // Storage is not reset; only the pointers define which words are live.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointer and occupancy update.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : mcb_fifo

// [test/mcb_mem.sv]
module mcb_mem (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Bench controls: strap level, beats owed, stall cycles per beat.
  input wire logic [3:0] strap,
  input wire logic [4:0] beats,
  input wire logic [2:0] wait_cyc,
  // Processor pins.
  input wire logic [31:0] ad_out,
  input wire logic ad_oe,
  input wire logic ale,
  input wire logic [3:0] low_addr_out,
  input wire logic low_addr_oe,
  output logic [31:0] ad_in,
  output logic [3:0] low_addr_in,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [27:0] hi; // Address latched under the strobe.
  logic [4:0] left; // Beats still owed.
  logic [2:0] cnt; // Stall cycles spent on this beat.
  logic [31:0] pat = 32'h0F0F_0F0F; // Released lines flip each cycle.
  // Diag and the strobes are never looked at here.
  assign mem_ack = (left != 5'h0) && !ale && (cnt >= wait_cyc);
  // Read data is driven only while the processor has let go.
  assign ad_in = ad_oe ? ad_out : (left != 5'h0) ? ({hi, low_addr_out} ^ 32'hC3C3_C3C3) : pat;
  // The strap resistors win only while the pins are not driven.
  assign low_addr_in = low_addr_oe ? low_addr_out : strap;
  // Latch on the strobe, then count beats down.
  always @(posedge clock) begin
    pat <= ~pat;
    if (!resetn) begin
      left <= 5'h0;
      cnt <= 3'h0;
    end else if (ale) begin
      hi <= ad_out[31:4];
      left <= beats;
      cnt <= 3'h0;
    end else if (mem_ack) begin
      left <= left - 5'h1;
      cnt <= 3'h0;
    end else if (left != 5'h0) begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule : mcb_mem

// [test/mcb_bus_tb.sv]
module mcb_bus_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcb_pkg::*;
  // Clock, reset and bus master drive.
  logic clock = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, wr_addr = 32'h0, wr_data = 32'h0;
  logic [31:0] rd_addr = 32'h0, rdata, ad_in, ad_out;
  logic pready, pslverr, wr_valid = 1'h0, wr_ready, rd_req_valid = 1'h0, rd_req_ready;
  logic [1:0] wr_size = 2'h0, rd_size = 2'h0, port_width = 2'h2;
  logic rd_quad = 1'h0, rd_miss = 1'h0, rd_instr = 1'h0, rdata_valid, rdata_last;
  // Straps, pins and partner controls.
  logic boot_rom_halfword_opt, boot_rom_byte_opt, spare_high_opt, long_latch_hold_opt;
  logic mem_ack, ad_oe, ale, diag, low_addr_oe;
  logic [3:0] low_addr_in, low_addr_out, strap = 4'h0;
  logic [4:0] beats = 5'h1;
  logic [2:0] wait_cyc = 3'h0;
  int seed = 17301, error_cnt = 0, cmp_count = 0;
  // Observed strobe cycles, beats and returned words.
  logic [36:0] a_q[$];
  logic [37:0] b_q[$];
  logic [32:0] r_q[$];

  mcb_bus uut (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .wr_valid, .wr_ready, .wr_addr, .wr_size, .wr_data, .rd_req_valid,
    .rd_req_ready, .rd_addr, .rd_size, .rd_quad, .rd_miss, .rd_instr, .rdata_valid, .rdata,
    .rdata_last, .boot_rom_halfword_opt, .boot_rom_byte_opt, .spare_high_opt,
    .long_latch_hold_opt, .port_width, .mem_ack, .ad_in, .ad_out, .ad_oe, .ale, .diag,
    .low_addr_in, .low_addr_out, .low_addr_oe);
  mcb_mem mem (.clock, .resetn, .strap, .beats, .wait_cyc, .ad_out, .ad_oe, .ale,
    .low_addr_out, .low_addr_oe, .ad_in, .low_addr_in, .mem_ack);

  always #5 clock = ~clock;

  // Record pins at each edge; queues keep the order the bus produced.
  always @(posedge clock) begin
    if (ale) a_q.push_back({diag, low_addr_out, ad_out});
    if (mem_ack) b_q.push_back({ad_oe, diag, low_addr_out, ad_out});
    if (rdata_valid) r_q.push_back({rdata_last, rdata});
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Lane mask; big endian mirrors it.
  function automatic logic [3:0] lanes(input logic [1:0] a, input logic [1:0] s,
                                       input logic big);
    logic [3:0] m;
    m = (s == MCB_SZ_BYTE) ? 4'h1 << a : (s == MCB_SZ_HALF) ? 4'h3 << {a[1], 1'h0} : 4'hF;
    lanes = big ? {m[0], m[1], m[2], m[3]} : m;
  endfunction : lanes

  // Called just after an edge; one idle cycle follows so calls may chain.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (!pready) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb

  // Wait until the bus is idle and the write buffer has drained.
  task automatic idle();
    repeat (3) @(posedge clock);
    while (!rd_req_ready) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask : idle

  // One read, single or quad, on a port of width pw; cv holds the hold and byte order bits.
  task automatic rd_chk(input logic [31:0] a, input logic q, input logic [1:0] pw,
                        input logic [1:0] cv);
    logic m, i;
    logic [1:0] sz;
    logic [3:0] la;
    logic [31:0] w, msk;
    logic [36:0] av;
    logic [37:0] bv;
    int nb, k, sh;
    m = $random(seed);
    i = $random(seed);
    // Narrow ports and quads take whole words; a single read on a full-width port also gets bytes and halves.
    sz = (q || pw != MCB_SZ_WORD) ? MCB_SZ_WORD : 2'({$random(seed)} % 3);
    nb = q ? (16 >> pw) : (4 >> pw);
    msk = 32'hFFFF_FFFF >> (32 - (8 << pw));
    port_width <= pw;
    beats <= 5'(nb);
    wait_cyc <= 3'($random(seed));
    rd_addr <= a;
    rd_size <= sz;
    rd_quad <= q;
    rd_miss <= m;
    rd_instr <= i;
    rd_req_valid <= 1'h1;
    @(posedge clock);
    while (!rd_req_ready) @(posedge clock);
    rd_req_valid <= 1'h0;
    idle();
    la = q ? 4'h0 : a[3:0];
    av = a_q.pop_front();
    check(av[36:4], {m, la, a[31:4]});
    if (pw == MCB_SZ_WORD) check(av[3:0], cv[0] ? 4'hF : {~lanes(a[1:0], sz, cv[1])});
    w = 32'h0;
    for (k = 0; k < nb; k++) begin
      bv = b_q.pop_front();
      check(bv[37:32], {1'h0, i, la});
      // Big endian mirrors the narrow beat's byte position within the word.
      sh = cv[1] ? 4 - (1 << pw) - la[1:0] : la[1:0];
      w = w | ((({a[31:4], la} ^ 32'hC3C3_C3C3) & msk) << (8 * sh));
      if (k == nb - 1 || ({1'h0, la[1:0]} + (3'h1 << pw)) > 3'h3) begin
        check(r_q.pop_front(), {k == nb - 1, w});
        w = 32'h0;
      end
      la = la + (4'h1 << pw);
    end
    $display("Test read done, quad %0d port %0d", q, pw);
  endtask : rd_chk

  initial begin
    logic [31:0] r, a, d;
    logic [31:0] ea[6], ed[6];
    logic [1:0] s;
    logic [1:0] es[6];
    logic e, full;
    logic [36:0] av;
    logic [37:0] bv;
    int n, big;
    strap = 4'($random(seed));
    repeat (10) @(posedge clock);
    resetn <= 1'h1;
    @(posedge clock);
    check({long_latch_hold_opt, spare_high_opt, boot_rom_byte_opt, boot_rom_halfword_opt},
          strap);
    apb(1'h0, MCB_STATUS_OFF, 32'h0, r, e);
    check({r, e}, {28'h0, strap, 1'h0});
    apb(1'h0, MCB_CTRL_OFF, 32'h0, r, e);
    check({r, e}, 33'h0);
    apb(1'h1, MCB_CTRL_OFF, 32'hFFFF_FFFF, r, e);
    apb(1'h0, MCB_CTRL_OFF, 32'h0, r, e);
    check({r, e}, {32'h3, 1'h0});
    apb(1'h1, MCB_STATUS_OFF, 32'hFF, r, e);
    check(e, 1'h1);
    apb(1'h0, 12'h008, 32'h0, r, e);
    check({r, e}, {32'h0, 1'h1});
    $display("Test registers done");
    // Writes stall at the far side so the buffer fills and refuses.
    // The second pass also sets the hold bit, which must leave store strobes alone.
    for (big = 0; big < 2; big++) begin
      apb(1'h1, MCB_CTRL_OFF, big ? 32'h3 : 32'h0, r, e);
      wait_cyc <= 3'h5;
      port_width <= MCB_SZ_WORD;
      beats <= 5'h1;
      full = 1'h0;
      for (n = 0; n < 6; n++) begin
        s = (n == 0) ? MCB_SZ_BYTE : 2'({$random(seed)} % 3);
        a = (n == 0) ? 32'hFFFF_FFFF : $random(seed) & ~((32'h1 << s) - 32'h1);
        d = $random(seed);
        ea[n] = a;
        es[n] = s;
        ed[n] = d;
        wr_valid <= 1'h1;
        wr_addr <= a;
        wr_size <= s;
        wr_data <= d;
        @(posedge clock);
        while (!wr_ready) begin
          full = 1'h1;
          @(posedge clock);
        end
      end
      wr_valid <= 1'h0;
      idle();
      check(full, 1'h1);
      for (n = 0; n < 6; n++) begin
        av = a_q.pop_front();
        bv = b_q.pop_front();
        check(av[35:0], {ea[n][3:0], ea[n][31:4], ~lanes(ea[n][1:0], es[n], big[0])});
        check({bv[37], bv[35:32]}, {1'h1, ea[n][3:0]});
        if (es[n] == MCB_SZ_WORD) check(bv[31:0], ed[n]);
      end
      $display("Test writes done, big %0d", big);
    end
    apb(1'h1, MCB_CTRL_OFF, 32'h0, r, e);
    a = $random(seed) & 32'hFFFF_FFFC;
    rd_chk(a, 1'h1, MCB_SZ_WORD, 1'h0);
    rd_chk(a + 32'h10, 1'h0, MCB_SZ_BYTE, 1'h0);
    rd_chk(a ^ 32'h8, 1'h0, MCB_SZ_HALF, 1'h0);
    apb(1'h1, MCB_CTRL_OFF, 32'h1, r, e);
    rd_chk(a, 1'h0, MCB_SZ_WORD, 1'h1);
    rd_chk(a, 1'h1, MCB_SZ_BYTE, 1'h1);
    apb(1'h1, MCB_CTRL_OFF, 32'h2, r, e);
    rd_chk(a + 32'h20, 1'h0, MCB_SZ_BYTE, 2'h2);
    rd_chk(a ^ 32'h4, 1'h1, MCB_SZ_HALF, 2'h2);
    rd_chk(a, 1'h0, MCB_SZ_WORD, 2'h2);
    // Reset again mid-run: pins are released, straps caught anew, control cleared.
    strap <= ~strap;
    resetn <= 1'h0;
    repeat (3) @(posedge clock);
    check({ale, ad_oe, low_addr_oe, rdata_valid}, 4'h0);
    resetn <= 1'h1;
    repeat (2) @(posedge clock);
    check({low_addr_oe, long_latch_hold_opt, spare_high_opt, boot_rom_byte_opt,
           boot_rom_halfword_opt}, {1'h1, strap});
    apb(1'h0, MCB_CTRL_OFF, 32'h0, r, e);
    check({r, e}, {30'h0, MCB_CTRL_RESET, 1'h0});
    $display("Test mid-run reset done");
    // Every latch strobe, beat and word seen must have been accounted for.
    check(a_q.size() + b_q.size() + r_q.size(), 0);
    final_report();
  end

  // The run needs a few hundred cycles; 20000 leaves ample margin.
  initial begin
    #200000;
    error_cnt++;
    $display("ERROR t=%0t watchdog seen=%h exp=%h", $time, 1'h0, 1'h1);
    final_report();
  end
endmodule : mcb_bus_tb
